// [design/etd_map.vh]
// Notes on behaviour
// [RULE1] Instance two selector: 0/A-F off, 1-9 slot
// [RULE2] Instance one selector uses same slot encoding
// [RULE3] Instance two channel bit: 0 ch1, 1 ch2
// [RULE4] Instance one channel bit: 0 ch1, 1 ch2
// [RULE5] Persistence code gives 1, 2, 4, 8 samples
// [RULE6] Level hysteresis code gives 0 or 2..128 counts
// [RULE7] Upper: enter above U+h/2, stay above U-h/2
// [RULE8] Lower: enter below L-h/2, stay below L+h/2
// [RULE9] One hysteresis and persistence setting for both
// [RULE10] Threshold step 2048 counts; upper zero disables
// [RULE11] Software keeps upper above lower, else undefined
// [RULE12] Lower code zero disables lower detection
// [RULE13] Only selected slot/channel; broken run restarts count
`ifndef ETD_MAP_VH
`define ETD_MAP_VH

// ----------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------
`define ETD_IDX_MEAS_SEL 10'h068
`define ETD_IDX_HYST 10'h069
`define ETD_IDX_UPPER1 10'h06a
`define ETD_IDX_LOWER1 10'h06b
`define ETD_IDX_UPPER2 10'h06c
`define ETD_IDX_LOWER2 10'h06d
`define ETD_IDX_IRQ_STATUS 10'h078
`define ETD_IDX_IRQ_ENABLE 10'h079
`define ETD_IDX_IRQ_CLEAR 10'h07a
`define ETD_IDX_LIVE_STATE 10'h07b

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ETD_RST_MEAS_SEL 8'h00
`define ETD_RST_HYST 8'h00
`define ETD_RST_UPPER 8'hff
`define ETD_RST_LOWER 8'h00
`define ETD_RST_IRQ_ENABLE 4'h0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ETD_SEL1_LSB 0
`define ETD_SEL2_LSB 4
`define ETD_LEVEL_HYSTERESIS_MAGNITUDE_LSB 0
`define ETD_PERSIST_LSB 3
`define ETD_CHSEL1_BIT 6
`define ETD_CHSEL2_BIT 7
`define ETD_HYST_MASK 8'hdf
`define ETD_SLOT_MAX 4'h9
`define ETD_STEP_SHIFT 11

// Status bits
`define ETD_ST_UP1 0
`define ETD_ST_LO1 1
`define ETD_ST_UP2 2
`define ETD_ST_LO2 3

`endif

// [design/etd_detector.v]
`timescale 1ns/1ns
`default_nettype none
`include "etd_map.vh"

module etd_detector (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Sample feed, already filtered for slot and channel
    input wire enable,
    input wire sample_valid,
    input wire [19:0] sample_data,
    // Settings
    input wire [7:0] upper_code,
    input wire [7:0] lower_code,
    input wire [2:0] hyst_code,
    input wire [1:0] persist_code,
    // Events and state
    output reg hit_upper,
    output reg hit_lower,
    output reg [2:0] state,
    output reg [3:0] run_count
);

localparam ST_IDLE = 3'd0;
localparam ST_UP_RUN = 3'd1;
localparam ST_LO_RUN = 3'd2;
localparam ST_UP_HELD = 3'd3;
localparam ST_LO_HELD = 3'd4;

// [RULE6] half hysteresis
function [20:0] half_hyst;
    input [2:0] code;
    begin
        if (code == 3'h0) begin
            half_hyst = 21'h0;
        end else begin
            half_hyst = 21'h1 << (code - 3'h1);
        end
    end
endfunction

// [RULE5] persistence count
function [3:0] need_count;
    input [1:0] code;
    begin
        need_count = 4'h1 << code;
    end
endfunction

wire [20:0] s = {1'b0, sample_data};
wire [20:0] hh = half_hyst(hyst_code);
// [RULE10] step scaling
wire [20:0] thr_up = {2'b00, upper_code, 11'h000};
wire [20:0] thr_lo = {2'b00, lower_code, 11'h000};
wire [3:0] need = need_count(persist_code);
wire [3:0] next_count = run_count + 4'h1;

// [RULE7] upper band
wire up_enter = (upper_code != 8'h00) && (s > thr_up + hh);
wire up_stay = (upper_code != 8'h00) && (s + hh > thr_up);
// [RULE8] lower band
// [RULE12] lower zero disables
wire lo_enter = (lower_code != 8'h00) && (s + hh < thr_lo);
wire lo_stay = (lower_code != 8'h00) && (s < thr_lo + hh);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state <= ST_IDLE;
        run_count <= 4'h0;
        hit_upper <= 1'b0;
        hit_lower <= 1'b0;
    end else begin
        hit_upper <= 1'b0;
        hit_lower <= 1'b0;
        if (!enable) begin
            state <= ST_IDLE;
            run_count <= 4'h0;
        end else if (sample_valid) begin
            case (state)
                ST_IDLE: begin
                    if (up_enter) begin
                        run_count <= 4'h1;
                        hit_upper <= (need == 4'h1);
                        state <= (need == 4'h1) ? ST_UP_HELD : ST_UP_RUN;
                    end else if (lo_enter) begin
                        run_count <= 4'h1;
                        hit_lower <= (need == 4'h1);
                        state <= (need == 4'h1) ? ST_LO_HELD : ST_LO_RUN;
                    end
                end
                // [RULE13] broken run restarts
                ST_UP_RUN: begin
                    if (up_stay) begin
                        run_count <= next_count;
                        hit_upper <= (next_count == need);
                        state <= (next_count == need) ? ST_UP_HELD : ST_UP_RUN;
                    end else begin
                        run_count <= 4'h0;
                        state <= ST_IDLE;
                    end
                end
                ST_LO_RUN: begin
                    if (lo_stay) begin
                        run_count <= next_count;
                        hit_lower <= (next_count == need);
                        state <= (next_count == need) ? ST_LO_HELD : ST_LO_RUN;
                    end else begin
                        run_count <= 4'h0;
                        state <= ST_IDLE;
                    end
                end
                // One event per excursion; rearm once the band is left
                ST_UP_HELD: begin
                    if (!up_stay) begin
                        run_count <= 4'h0;
                        state <= ST_IDLE;
                    end
                end
                ST_LO_HELD: begin
                    if (!lo_stay) begin
                        run_count <= 4'h0;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    run_count <= 4'h0;
                    state <= ST_IDLE;
                end
            endcase
        end
    end
end

endmodule
`default_nettype wire

// [design/etd_top.v]
`timescale 1ns/1ns
`default_nettype none
`include "etd_map.vh"

module etd_top (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Exposure samples from the sequencer
    input wire sample_valid,
    input wire [3:0] sample_slot,
    input wire sample_channel,
    input wire [19:0] sample_data,
    // Interrupt
    output reg irq
);

// ----------------------------------------
// Registers
// ----------------------------------------
reg [7:0] threshold_measurement_select;
reg [7:0] threshold_hysteresis_config;
reg [7:0] upper_threshold_one;
reg [7:0] lower_threshold_one;
reg [7:0] upper_threshold_two;
reg [7:0] lower_threshold_two;
reg [3:0] irq_status;
reg [3:0] irq_enable;

// ----------------------------------------
// Helpers
// ----------------------------------------
function slot_enabled;
    input [3:0] sel;
    begin
        slot_enabled = (sel != 4'h0) && (sel <= `ETD_SLOT_MAX);
    end
endfunction

function [9:0] word_index;
    input [11:0] addr;
    begin
        word_index = addr[11:2];
    end
endfunction

function idx_known;
    input [9:0] idx;
    begin
        case (idx)
            `ETD_IDX_MEAS_SEL: idx_known = 1'b1;
            `ETD_IDX_HYST: idx_known = 1'b1;
            `ETD_IDX_UPPER1: idx_known = 1'b1;
            `ETD_IDX_LOWER1: idx_known = 1'b1;
            `ETD_IDX_UPPER2: idx_known = 1'b1;
            `ETD_IDX_LOWER2: idx_known = 1'b1;
            `ETD_IDX_IRQ_STATUS: idx_known = 1'b1;
            `ETD_IDX_IRQ_ENABLE: idx_known = 1'b1;
            `ETD_IDX_IRQ_CLEAR: idx_known = 1'b1;
            `ETD_IDX_LIVE_STATE: idx_known = 1'b1;
            default: idx_known = 1'b0;
        endcase
    end
endfunction

// ----------------------------------------
// Field views
// ----------------------------------------
wire [3:0] first_instance_slot_select;
wire [3:0] second_instance_slot_select;
wire first_instance_channel_select;
wire second_instance_channel_select;
wire [1:0] sample_persistence_count;
wire [2:0] level_hysteresis_magnitude;

assign first_instance_slot_select =
    threshold_measurement_select[`ETD_SEL1_LSB +: 4];
assign second_instance_slot_select =
    threshold_measurement_select[`ETD_SEL2_LSB +: 4];
assign first_instance_channel_select =
    threshold_hysteresis_config[`ETD_CHSEL1_BIT];
assign second_instance_channel_select =
    threshold_hysteresis_config[`ETD_CHSEL2_BIT];
assign sample_persistence_count =
    threshold_hysteresis_config[`ETD_PERSIST_LSB +: 2];
assign level_hysteresis_magnitude =
    threshold_hysteresis_config[`ETD_LEVEL_HYSTERESIS_MAGNITUDE_LSB +: 3];

// ----------------------------------------
// Sample routing
// ----------------------------------------
wire inst1_enable;
wire inst2_enable;
wire inst1_take;
wire inst2_take;

// [RULE2] instance one selector
assign inst1_enable = slot_enabled(first_instance_slot_select);
// [RULE1] instance two selector
assign inst2_enable = slot_enabled(second_instance_slot_select);

// [RULE13] slot and channel filter
// [RULE4] instance one channel
assign inst1_take = sample_valid && inst1_enable &&
    (sample_slot == first_instance_slot_select) &&
    (sample_channel == first_instance_channel_select);
// [RULE3] instance two channel
assign inst2_take = sample_valid && inst2_enable &&
    (sample_slot == second_instance_slot_select) &&
    (sample_channel == second_instance_channel_select);

// ----------------------------------------
// Detector instances
// ----------------------------------------
wire inst1_hit_upper;
wire inst1_hit_lower;
wire inst2_hit_upper;
wire inst2_hit_lower;
wire [2:0] inst1_state;
wire [2:0] inst2_state;
wire [3:0] inst1_count;
wire [3:0] inst2_count;

// [RULE9] shared hysteresis settings
etd_detector u_inst1 (
    .pclk(pclk),
    .presetn(presetn),
    .enable(inst1_enable),
    .sample_valid(inst1_take),
    .sample_data(sample_data),
    .upper_code(upper_threshold_one),
    .lower_code(lower_threshold_one),
    .hyst_code(level_hysteresis_magnitude),
    .persist_code(sample_persistence_count),
    .hit_upper(inst1_hit_upper),
    .hit_lower(inst1_hit_lower),
    .state(inst1_state),
    .run_count(inst1_count)
);

etd_detector u_inst2 (
    .pclk(pclk),
    .presetn(presetn),
    .enable(inst2_enable),
    .sample_valid(inst2_take),
    .sample_data(sample_data),
    .upper_code(upper_threshold_two),
    .lower_code(lower_threshold_two),
    .hyst_code(level_hysteresis_magnitude),
    .persist_code(sample_persistence_count),
    .hit_upper(inst2_hit_upper),
    .hit_lower(inst2_hit_lower),
    .state(inst2_state),
    .run_count(inst2_count)
);

// ----------------------------------------
// APB decode
// ----------------------------------------
wire [9:0] idx;
wire setup_phase;
wire write_done;
wire byte0_on;

assign idx = word_index(paddr);
assign setup_phase = psel && !penable;
// Writes land only on the completing access edge
assign write_done = psel && penable && pready && pwrite && !pslverr;
assign byte0_on = pstrb[0];

reg [31:0] next_prdata;

always @* begin
    next_prdata = 32'h00000000;
    case (idx)
        `ETD_IDX_MEAS_SEL: next_prdata[7:0] = threshold_measurement_select;
        `ETD_IDX_HYST: next_prdata[7:0] = threshold_hysteresis_config;
        `ETD_IDX_UPPER1: next_prdata[7:0] = upper_threshold_one;
        `ETD_IDX_LOWER1: next_prdata[7:0] = lower_threshold_one;
        `ETD_IDX_UPPER2: next_prdata[7:0] = upper_threshold_two;
        `ETD_IDX_LOWER2: next_prdata[7:0] = lower_threshold_two;
        `ETD_IDX_IRQ_STATUS: next_prdata[3:0] = irq_status;
        `ETD_IDX_IRQ_ENABLE: next_prdata[3:0] = irq_enable;
        `ETD_IDX_LIVE_STATE: begin
            next_prdata[2:0] = inst1_state;
            next_prdata[7:4] = inst1_count;
            next_prdata[10:8] = inst2_state;
            next_prdata[15:12] = inst2_count;
        end
        default: next_prdata = 32'h00000000;
    endcase
end

// One access cycle: pready rises for the cycle after setup
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end else begin
        pready <= setup_phase;
        // Error stands only beside ready, so it never leaks into the next setup
        pslverr <= setup_phase && !idx_known(idx);
        if (setup_phase) begin
            prdata <= pwrite ? 32'h00000000 : next_prdata;
        end
    end
end

// ----------------------------------------
// Configuration registers
// ----------------------------------------
// [RULE11] Upper above lower is left to software; no check is made
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        threshold_measurement_select <= `ETD_RST_MEAS_SEL;
        threshold_hysteresis_config <= `ETD_RST_HYST;
        upper_threshold_one <= `ETD_RST_UPPER;
        lower_threshold_one <= `ETD_RST_LOWER;
        upper_threshold_two <= `ETD_RST_UPPER;
        lower_threshold_two <= `ETD_RST_LOWER;
        irq_enable <= `ETD_RST_IRQ_ENABLE;
    end else if (write_done && byte0_on) begin
        case (idx)
            `ETD_IDX_MEAS_SEL: threshold_measurement_select <= pwdata[7:0];
            // Reserved bit 5 is dropped so it always reads zero
            `ETD_IDX_HYST: threshold_hysteresis_config <= pwdata[7:0] & `ETD_HYST_MASK;
            `ETD_IDX_UPPER1: upper_threshold_one <= pwdata[7:0];
            `ETD_IDX_LOWER1: lower_threshold_one <= pwdata[7:0];
            `ETD_IDX_UPPER2: upper_threshold_two <= pwdata[7:0];
            `ETD_IDX_LOWER2: lower_threshold_two <= pwdata[7:0];
            `ETD_IDX_IRQ_ENABLE: irq_enable <= pwdata[3:0];
            default: irq_enable <= irq_enable;
        endcase
    end
end

// ----------------------------------------
// Interrupt status
// ----------------------------------------
wire [3:0] irq_events;
wire [3:0] irq_clear;
wire [3:0] next_status;

assign irq_events[`ETD_ST_UP1] = inst1_hit_upper;
assign irq_events[`ETD_ST_LO1] = inst1_hit_lower;
assign irq_events[`ETD_ST_UP2] = inst2_hit_upper;
assign irq_events[`ETD_ST_LO2] = inst2_hit_lower;

assign irq_clear = (write_done && byte0_on && idx == `ETD_IDX_IRQ_CLEAR) ?
    pwdata[3:0] : 4'h0;

// A hit in the clearing cycle survives: set beats clear
assign next_status = (irq_status & ~irq_clear) | irq_events;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        irq_status <= 4'h0;
        irq <= 1'b0;
    end else begin
        irq_status <= next_status;
        irq <= |(next_status & irq_enable);
    end
end

endmodule
`default_nettype wire

// [verif/etd_properties.sv]
`timescale 1ns/1ns
`default_nettype none
module etd_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Events
    input wire logic sample_valid,
    input wire logic irq
);
    wire [9:0] idx;
    wire mapped;
    wire wr_access;
    assign idx = paddr[11:2];
    assign wr_access = psel && penable && pwrite;
    assign mapped = (idx >= 10'h068 && idx <= 10'h06d) || (idx >= 10'h078 && idx <= 10'h07b);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Bus timing and interrupt causes
    // ----------------------------------------
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    property p_one_wait;
        s_setup |=> s_access;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("no ready after setup");
    property p_ready_in_access;
        pready |-> psel && penable;
    endproperty
    a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    property p_err_unmapped;
        psel && !penable && !mapped |=> pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("no error on unmapped");
    property p_no_err_mapped;
        psel && !penable && mapped |=> !pslverr;
    endproperty
    a_no_err_mapped: assert property (p_no_err_mapped) else $error("error on mapped index");
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
    property p_clear_reads_zero;
        psel && !penable && !pwrite && idx == 10'h07a |=> prdata == 32'h0;
    endproperty
    a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear index not zero");
    property p_upper_zero;
        pready |-> prdata[31:16] == 16'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    property p_irq_rise;
        $rose(irq) |-> $past(sample_valid, 2) || $past(wr_access, 2);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
    property p_irq_fall;
        $fell(irq) |-> $past(wr_access) || $past(wr_access, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
endmodule
bind etd_top etd_props u_props (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .sample_valid(sample_valid),
    .irq(irq)
);
`default_nettype wire

// [verif/exposure_threshold_detector_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module exposure_threshold_detector_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic sample_valid, sample_channel;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, sample_slot;
    logic [19:0] sample_data;
    integer fail_count = 0, n_checks = 0, seed = 91066, i, c;
    logic [9:0] ridx [0:10] = '{10'h068, 10'h069, 10'h06a, 10'h06b, 10'h06c, 10'h06d,
                               10'h078, 10'h079, 10'h07a, 10'h07b, 10'h070};
    logic [7:0] rexp [0:10] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00,
                               8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    etd_top uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sample_valid), .sample_slot(sample_slot),
        .sample_channel(sample_channel), .sample_data(sample_data), .irq(irq)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function integer half(input integer lc);
        half = (lc == 0) ? 0 : (1 << (lc - 1));
    endfunction
    function integer nsamp(input integer pc);
        nsamp = (pc == 0) ? 1 : (1 << pc);
    endfunction
    task check(input string name, input [31:0] seen, input [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task give_verdict;
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Holds the request until ready; waits only on the bench watchdog's bound
    task apb(input logic w, input [9:0] idx, input [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task smp(input [3:0] s, input logic ch, input [19:0] d);
        @(posedge pclk);
        sample_valid <= 1'b1;
        sample_slot <= s;
        sample_channel <= ch;
        sample_data <= d;
        @(posedge pclk);
        sample_valid <= 1'b0;
    endtask
    task st(input [3:0] exp);
        repeat (3) @(posedge pclk);
        apb(1'b0, 10'h078, 8'h00);
        check("status", rd, exp);
    endtask
    // ----------------------------------------
    // Random detection case
    // ----------------------------------------
    task run_case;
        integer k, lo, slot, ch, lc, pc, th, h, nn, base, vin, vst, vbk, vbd, j, r;
        logic [3:0] ex, en;
        k = {$random(seed)} % 2;
        lo = {$random(seed)} % 2;
        slot = {$random(seed)} % 9 + 1;
        ch = {$random(seed)} % 2;
        lc = {$random(seed)} % 8;
        pc = {$random(seed)} % 4;
        r = {$random(seed)} % 6 + 10;
        th = (!lo && {$random(seed)} % 6 == 0) ? 0 : {$random(seed)} % 249 + 2;
        h = half(lc);
        nn = nsamp(pc);
        base = th * 2048;
        vin = lo ? base - h - 1 : base + h + 1;
        vbd = lo ? base - h : base + h;
        vst = lo ? base + h - 1 : base - h + 1;
        vbk = lo ? base + h : base - h;
        ex = (th == 0) ? 4'h0 : 4'h1 << (2 * k + lo);
        en = ({$random(seed)} % 2) ? 4'hf : ~ex;
        apb(1'b1, 10'h068, 8'h00);
        apb(1'b1, 10'h069, {ch[0], ch[0], 1'b0, pc[1:0], lc[2:0]});
        for (j = 0; j < 4; j++)
            apb(1'b1, 10'h06a + j[9:0], (j % 2) ? (lo ? th[7:0] : 8'h00) : (lo ? 8'hff : th[7:0]));
        apb(1'b1, 10'h079, {4'h0, en});
        apb(1'b1, 10'h07a, 8'h0f);
        apb(1'b1, 10'h068, k ? {slot[3:0], r[3:0]} : {r[3:0], slot[3:0]});
        for (j = 0; j < nn; j++) begin
            smp(slot % 9 + 1, ch[0], vin[19:0]);
            smp(slot[3:0], !ch[0], vin[19:0]);
            smp(r[3:0], ch[0], vin[19:0]);
        end
        smp(slot[3:0], ch[0], vbd[19:0]);
        st(4'h0);
        if (nn > 1 && th > 0) begin
            smp(slot[3:0], ch[0], vin[19:0]);
            for (j = 2; j < nn; j++)
                smp(slot[3:0], ch[0], vst[19:0]);
            smp(slot[3:0], ch[0], vbk[19:0]);
        end
        smp(slot[3:0], ch[0], vin[19:0]);
        for (j = 1; j < nn; j++) begin
            if (j == nn - 1)
                st(4'h0);
            smp(slot[3:0], ch[0], vst[19:0]);
        end
        st(ex);
        check("irq", irq, |(ex & en));
        apb(1'b1, 10'h07a, 8'h0f);
        st(4'h0);
        check("irq after clear", irq, 1'b0);
        $display("case %0d done", c);
    endtask

    initial begin
        #500000;
        fail_count++;
        give_verdict;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        sample_valid = 1'b0;
        sample_slot = 4'h0;
        sample_channel = 1'b0;
        sample_data = 20'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 11; i++) begin
            apb(1'b0, ridx[i], 8'h00);
            check("reset value", rd, {24'h0, rexp[i]});
            check("bus error", err, i == 10);
        end
        apb(1'b1, 10'h069, 8'hff);
        apb(1'b0, 10'h069, 8'h00);
        check("hysteresis readback", rd, 32'hdf);
        pstrb <= 4'h0;
        apb(1'b1, 10'h06a, 8'h12);
        pstrb <= 4'hf;
        apb(1'b0, 10'h06a, 8'h00);
        check("masked write", rd, 32'hff);
        $display("register test done");
        for (c = 0; c < 24; c++)
            run_case;
        give_verdict;
    end
endmodule
`default_nettype wire
